// *** shared/alz_params.svh ***
// Constants for the ambient-light zone backlight block: offsets, reset values, timing.
// Assumes a 20 MHz system clock and an 8-bit converter code for the sensing input.
// What this block does
// - Four 8-bit boundaries split input into five zones
// - Zone change ramps LED level, not one step
// - Config bit6 sense, bit5 group B, bit4 group A
// - Boundaries reset to 0x33, 0x66, 0x99, 0xcc
// - Boundary registers are 8-bit, read and write
// - Zone targets reset 0x19,0x33,0x4c,0x66,0x7f
// - Register 0x10 enables sinks; 0x3f lights six
// - Sense control 0x40 selects 400 ms averaging
// - Register 0x51 picks sense pulldown; 0x40 is 2.32k
// - Sample at 16 kHz, average whole period
// - Eight selectable averaging periods
// - Steady change acts within three averaging cycles
// - Stored starting reading is zone zero
// - Fractional zone average truncates downward
// - Decisions use the three latest averager outputs
// - Raise zone on up then up or rest
// - Lower zone on down then down or rest
// - Two moves adopt the latest averager zone
// - Averaging cycle free-running, unsynchronised to input
// - Config bit0 scales zone level by PWM duty
// - Status gives 3-bit zone and read-clear flag
// - Averaging code 000 is 25 ms, doubling to 3.2 s
`ifndef ALZ_PARAMS_SVH
`define ALZ_PARAMS_SVH

// Register offsets
`define ALZ_ADDR_LED_CTRL 8'h10
`define ALZ_ADDR_CONFIG 8'h20
`define ALZ_ADDR_ZONE_STAT 8'h40
`define ALZ_ADDR_SENSE_CTRL 8'h50
`define ALZ_ADDR_RES_SEL 8'h51
`define ALZ_ADDR_BOUND_BASE 8'h60
`define ALZ_ADDR_TARGET_BASE 8'h70
`define ALZ_ADDR_GRPA_BRT 8'ha0
`define ALZ_ADDR_GRPB_BRT 8'hb0

// Configuration bit positions
`define ALZ_CFG_SENSE_EN 6
`define ALZ_CFG_GRPB_EN 5
`define ALZ_CFG_GRPA_EN 4
`define ALZ_CFG_PWM_EN 0

// Reset values
`define ALZ_BOUND0_RST 8'h33
`define ALZ_BOUND1_RST 8'h66
`define ALZ_BOUND2_RST 8'h99
`define ALZ_BOUND3_RST 8'hcc
`define ALZ_TARGET0_RST 7'h19
`define ALZ_TARGET1_RST 7'h33
`define ALZ_TARGET2_RST 7'h4c
`define ALZ_TARGET3_RST 7'h66
`define ALZ_TARGET4_RST 7'h7f
`define ALZ_REVISION 2'h2 // Arbitrary value

// Timing
`define ALZ_CLK_HZ 20000000
`define ALZ_SAMPLE_HZ 16000
`define ALZ_SAMPLE_DIV 11'((`ALZ_CLK_HZ) / (`ALZ_SAMPLE_HZ))
`define ALZ_BASE_PERIOD_MS 25
`define ALZ_BASE_SAMPLES 16'((`ALZ_BASE_PERIOD_MS) * (`ALZ_SAMPLE_HZ) / 1000)
`define ALZ_RAMP_STEP_US 100
`define ALZ_RAMP_DIV 11'((`ALZ_CLK_HZ) / 1000000 * (`ALZ_RAMP_STEP_US))

`endif

// *** shared/alz_pkg.sv ***
// Types shared by the ambient-light zone backlight block.
// Assumes the constants header is included by the design files.
package alz_pkg;
  // Serial port state
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_DEV, I2C_DEV_ACK, I2C_PTR, I2C_PTR_ACK,
    I2C_WR, I2C_WR_ACK, I2C_RD, I2C_RD_ACK
  } alz_i2c_state_t;
  // Direction of the last averager step
  typedef enum logic [1:0] {TR_REST, TR_UP, TR_DOWN} alz_trend_t;
endpackage

// *** rtl/alz_i2c_slave.sv ***
// I2C-compatible register port: device address, pointer byte, auto-increment.
// Assumes SCL and SDA come from pins; both pass two flip-flops before use.
`timescale 1ns/1ps
module alz_i2c_slave
  import alz_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h36 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register side
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr_stb,
  output logic reg_rd_stb,
  input wire logic [7:0] reg_rdata
);
  logic scl_s1, scl_s2, scl_d; // SCL synchroniser and delay
  logic sda_s1, sda_s2, sda_d; // SDA synchroniser and delay
  logic scl_rise, scl_fall, bus_start, bus_stop;
  alz_i2c_state_t state_reg;
  logic [3:0] bit_cnt_reg; // Bits seen in this byte
  logic [7:0] shift_reg; // Byte being received or sent
  logic read_reg; // Read direction latched from address byte

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // Open drain: only ever pulls low
  always_ff @(posedge clk) begin
    sda_out <= 1'b0;
  end

  // Protocol engine; SDA changes only after SCL falls
  always_ff @(posedge clk) begin
    reg_wr_stb <= 1'b0;
    reg_rd_stb <= 1'b0;
    if (sys_rst || bus_stop) begin
      state_reg <= I2C_IDLE;
      sda_oe <= 1'b0;
      bit_cnt_reg <= 4'h0;
      if (sys_rst) begin
        shift_reg <= 8'h00;
        read_reg <= 1'b0;
        reg_addr <= 8'h00;
        reg_wdata <= 8'h00;
      end
    end else if (bus_start) begin
      // Start or repeated start
      state_reg <= I2C_DEV;
      sda_oe <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        I2C_IDLE: begin
        end
        I2C_DEV, I2C_PTR, I2C_WR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            sda_oe <= 1'b1;
            if (state_reg == I2C_DEV) begin
              // Ignore other devices' traffic
              if (shift_reg[7:1] == DEV_ADDR) begin
                read_reg <= shift_reg[0];
                state_reg <= I2C_DEV_ACK;
              end else begin
                sda_oe <= 1'b0;
                state_reg <= I2C_IDLE;
              end
            end else if (state_reg == I2C_PTR) begin
              reg_addr <= shift_reg;
              state_reg <= I2C_PTR_ACK;
            end else begin
              reg_wdata <= shift_reg;
              reg_wr_stb <= 1'b1;
              state_reg <= I2C_WR_ACK;
            end
          end
        end
        I2C_DEV_ACK, I2C_PTR_ACK, I2C_WR_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            if (state_reg == I2C_WR_ACK) begin
              reg_addr <= reg_addr + 8'h01;
            end
            if (state_reg == I2C_DEV_ACK && read_reg) begin
              // First read byte loads now; read side effects fire here
              shift_reg <= reg_rdata;
              reg_rd_stb <= 1'b1;
              sda_oe <= ~reg_rdata[7];
              state_reg <= I2C_RD;
            end else begin
              state_reg <= (state_reg == I2C_DEV_ACK) ? I2C_PTR : I2C_WR;
            end
          end
        end
        I2C_RD: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              // Release for the master's acknowledge
              sda_oe <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= I2C_RD_ACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe <= ~shift_reg[6];
            end
          end
        end
        I2C_RD_ACK: begin
          if (scl_rise) begin
            if (sda_s2) begin
              state_reg <= I2C_IDLE;
            end else begin
              reg_addr <= reg_addr + 8'h01;
            end
          end else if (scl_fall) begin
            shift_reg <= reg_rdata;
            reg_rd_stb <= 1'b1;
            sda_oe <= ~reg_rdata[7];
            state_reg <= I2C_RD;
          end
        end
      endcase
    end
  end
endmodule

// *** rtl/alz_backlight_zone.sv ***
// Ambient-light zone logic: averager, discriminator, level ramp, PWM scaling, registers.
// Assumes an external converter delivers an 8-bit code and registers arrive over I2C.
`timescale 1ns/1ps
`include "alz_params.svh"
module alz_backlight_zone
  import alz_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Sensing input, converter code
  input wire logic [7:0] ambient_code,
  // External duty-cycle input
  input wire logic pwm_in,
  // Analog front end and sink controls
  output logic [3:0] sense_res_sel,
  output logic [7:0] sink_enable,
  output logic [6:0] main_group_level,
  output logic [6:0] secondary_group_level,
  output logic [2:0] current_zone
);
  // Register port wiring
  logic [7:0] bus_addr, bus_wdata, bus_rdata;
  logic bus_wr, bus_rd;
  // Software-visible storage
  logic [7:0] led_ctrl_reg, config_reg, sense_ctrl_reg, res_sel_reg;
  logic [7:0] bound_reg [0:3];
  logic [6:0] target_reg [0:4];
  logic [6:0] grpa_brt_reg, grpb_brt_reg;
  logic flag_reg; // Zone transition flag
  // Converter code synchroniser
  logic [7:0] code_s1, code_s2;
  // Sample divider and averager
  logic [10:0] sample_div_reg;
  logic sample_tick;
  logic [15:0] sample_cnt_reg; // Samples in this period
  logic [17:0] sum_reg; // Zone index sum
  logic [17:0] avg_sum_reg; // Sum of finished period
  logic [2:0] avg_code_reg; // Period code the sum belongs to
  logic avg_done_reg;
  logic [15:0] period_samples;
  logic [2:0] sample_zone, avg_zone;
  logic [17:0] avg_scaled;
  // Discriminator
  logic [2:0] last_avg_reg, zone_reg;
  alz_trend_t trend_reg, trend_now;
  // Ramp and duty
  logic [10:0] ramp_div_reg;
  logic ramp_tick;
  logic [6:0] ramp_reg;
  logic pwm_s1, pwm_s2;
  logic [11:0] win_cnt_reg;
  logic [12:0] hi_cnt_reg;
  logic [7:0] duty_reg; // 0..128 of full scale
  logic [14:0] scaled_prod;
  logic sense_en, zone_a, zone_b;

  alz_i2c_slave u_port (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_addr(bus_addr),
    .reg_wdata(bus_wdata),
    .reg_wr_stb(bus_wr),
    .reg_rd_stb(bus_rd),
    .reg_rdata(bus_rdata)
  );

  // Boundary slot decode, shared by read and write
  function automatic logic is_bound(input logic [7:0] a);
    return a[7:2] == 6'(`ALZ_ADDR_BOUND_BASE >> 2);
  endfunction
  // Target slot decode, five slots from the base
  function automatic logic is_target(input logic [7:0] a);
    return a >= `ALZ_ADDR_TARGET_BASE && a <= `ALZ_ADDR_TARGET_BASE + 8'h04;
  endfunction
  // Reset value of each boundary
  function automatic logic [7:0] bound_rst(input int i);
    case (i)
      0: return `ALZ_BOUND0_RST;
      1: return `ALZ_BOUND1_RST;
      2: return `ALZ_BOUND2_RST;
      default: return `ALZ_BOUND3_RST;
    endcase
  endfunction
  // Reset value of each zone target
  function automatic logic [6:0] target_rst(input int i);
    case (i)
      0: return `ALZ_TARGET0_RST;
      1: return `ALZ_TARGET1_RST;
      2: return `ALZ_TARGET2_RST;
      3: return `ALZ_TARGET3_RST;
      default: return `ALZ_TARGET4_RST;
    endcase
  endfunction

  assign sense_en = config_reg[`ALZ_CFG_SENSE_EN];
  assign zone_a = sense_en & config_reg[`ALZ_CFG_GRPA_EN];
  assign zone_b = sense_en & config_reg[`ALZ_CFG_GRPB_EN];

  // Plain control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_ctrl_reg <= 8'h00;
      config_reg <= 8'h00;
      sense_ctrl_reg <= 8'h00;
      res_sel_reg <= 8'h00;
      grpa_brt_reg <= 7'h00;
      grpb_brt_reg <= 7'h00;
    end else if (bus_wr) begin
      if (bus_addr == `ALZ_ADDR_LED_CTRL) led_ctrl_reg <= bus_wdata;
      if (bus_addr == `ALZ_ADDR_CONFIG) config_reg <= bus_wdata;
      // averaging code write; low bits are fixed
      if (bus_addr == `ALZ_ADDR_SENSE_CTRL) sense_ctrl_reg <= {bus_wdata[7:4], 4'h0};
      if (bus_addr == `ALZ_ADDR_RES_SEL) res_sel_reg <= {bus_wdata[7:4], 4'h0};
      if (bus_addr == `ALZ_ADDR_GRPA_BRT) grpa_brt_reg <= bus_wdata[6:0];
      if (bus_addr == `ALZ_ADDR_GRPB_BRT) grpb_brt_reg <= bus_wdata[6:0];
    end
  end

  // Boundary and target tables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) bound_reg[i] <= bound_rst(i);
      for (int i = 0; i < 5; i++) target_reg[i] <= target_rst(i);
    end else if (bus_wr) begin
      if (is_bound(bus_addr)) bound_reg[bus_addr[1:0]] <= bus_wdata;
      if (is_target(bus_addr)) target_reg[bus_addr[2:0]] <= bus_wdata[6:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    bus_rdata = 8'h00;
    if (is_bound(bus_addr)) begin
      bus_rdata = bound_reg[bus_addr[1:0]];
    end else if (is_target(bus_addr)) begin
      // Top bit of a target always reads one
      bus_rdata = {1'b1, target_reg[bus_addr[2:0]]};
    end else begin
      case (bus_addr)
        `ALZ_ADDR_LED_CTRL: bus_rdata = led_ctrl_reg;
        `ALZ_ADDR_CONFIG: bus_rdata = config_reg;
        `ALZ_ADDR_ZONE_STAT: bus_rdata = {4'hf, flag_reg, zone_reg};
        `ALZ_ADDR_SENSE_CTRL: bus_rdata = {sense_ctrl_reg[7:4], 2'h0, `ALZ_REVISION};
        `ALZ_ADDR_RES_SEL: bus_rdata = res_sel_reg;
        `ALZ_ADDR_GRPA_BRT: bus_rdata = {1'b0, grpa_brt_reg};
        `ALZ_ADDR_GRPB_BRT: bus_rdata = {1'b0, grpb_brt_reg};
        default: bus_rdata = 8'h00;
      endcase
    end
  end

  // Transition flag; a change in the read cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_reg <= 1'b0;
    end else if (avg_done_reg && zone_reg != avg_zone && trend_reg != TR_REST &&
                 trend_now != (trend_reg == TR_UP ? TR_DOWN : TR_UP)) begin
      flag_reg <= 1'b1;
    end else if (bus_rd && bus_addr == `ALZ_ADDR_ZONE_STAT) begin
      flag_reg <= 1'b0;
    end
  end

  // Converter code synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      code_s1 <= 8'h00;
      code_s2 <= 8'h00;
    end else begin
      code_s1 <= ambient_code;
      code_s2 <= code_s1;
    end
  end

  // 16 kHz sample enable, free running
  always_ff @(posedge clk) begin
    if (sys_rst || sample_div_reg == `ALZ_SAMPLE_DIV - 11'd1) sample_div_reg <= 11'd0;
    else sample_div_reg <= sample_div_reg + 11'd1;
  end
  assign sample_tick = sample_div_reg == `ALZ_SAMPLE_DIV - 11'd1;

  // zone of one sample against four boundaries
  always_comb begin
    sample_zone = 3'd4;
    for (int i = 3; i >= 0; i--) begin
      if (code_s2 < bound_reg[i]) sample_zone = 3'(i);
    end
  end

  // period doubles per code step from 25 ms
  assign period_samples = `ALZ_BASE_SAMPLES << sense_ctrl_reg[6:4];

  // Averager: sums zone indices over whole period
  always_ff @(posedge clk) begin
    avg_done_reg <= 1'b0;
    if (sys_rst || !sense_en) begin
      sample_cnt_reg <= 16'd0;
      sum_reg <= 18'd0;
      if (sys_rst) begin
        avg_sum_reg <= 18'd0;
        avg_code_reg <= 3'd0;
      end
    end else if (sample_tick) begin
      if (sample_cnt_reg >= period_samples - 16'd1) begin
        avg_sum_reg <= sum_reg + 18'(sample_zone);
        avg_code_reg <= sense_ctrl_reg[6:4];
        avg_done_reg <= 1'b1;
        sample_cnt_reg <= 16'd0;
        sum_reg <= 18'd0;
      end else begin
        sample_cnt_reg <= sample_cnt_reg + 16'd1;
        sum_reg <= sum_reg + 18'(sample_zone);
      end
    end
  end

  // floor division by the sample count
  assign avg_scaled = avg_sum_reg >> avg_code_reg;
  always_comb begin
    if (avg_scaled >= 18'(4 * `ALZ_BASE_SAMPLES)) avg_zone = 3'd4;
    else if (avg_scaled >= 18'(3 * `ALZ_BASE_SAMPLES)) avg_zone = 3'd3;
    else if (avg_scaled >= 18'(2 * `ALZ_BASE_SAMPLES)) avg_zone = 3'd2;
    else if (avg_scaled >= 18'(`ALZ_BASE_SAMPLES)) avg_zone = 3'd1;
    else avg_zone = 3'd0;
  end

  // Step of the newest result against the one before
  always_comb begin
    if (avg_zone > last_avg_reg) trend_now = TR_UP;
    else if (avg_zone < last_avg_reg) trend_now = TR_DOWN;
    else trend_now = TR_REST;
  end

  // Discriminator: two confirming results needed before a move
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_avg_reg <= 3'd0;
      zone_reg <= 3'd0;
      trend_reg <= TR_REST;
    end else if (avg_done_reg) begin
      last_avg_reg <= avg_zone;
      trend_reg <= trend_now;
      if (trend_reg == TR_UP && trend_now != TR_DOWN) zone_reg <= avg_zone;
      if (trend_reg == TR_DOWN && trend_now != TR_UP) zone_reg <= avg_zone;
    end
  end

  // Ramp step enable
  always_ff @(posedge clk) begin
    if (sys_rst || ramp_tick) ramp_div_reg <= 11'd0;
    else ramp_div_reg <= ramp_div_reg + 11'd1;
  end
  assign ramp_tick = ramp_div_reg == `ALZ_RAMP_DIV - 11'd1;

  // one code per step toward the zone target
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ramp_reg <= `ALZ_TARGET0_RST;
    end else if (ramp_tick) begin
      if (ramp_reg < target_reg[zone_reg]) ramp_reg <= ramp_reg + 7'd1;
      else if (ramp_reg > target_reg[zone_reg]) ramp_reg <= ramp_reg - 7'd1;
    end
  end

  // Duty measurement over 4096-cycle windows
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_s1 <= 1'b0;
      pwm_s2 <= 1'b0;
      win_cnt_reg <= 12'h000;
      hi_cnt_reg <= 13'h0000;
      duty_reg <= 8'h80;
    end else begin
      pwm_s1 <= pwm_in;
      pwm_s2 <= pwm_s1;
      win_cnt_reg <= win_cnt_reg + 12'h001;
      if (win_cnt_reg == 12'hfff) begin
        duty_reg <= 8'((hi_cnt_reg + 13'(pwm_s2)) >> 5);
        hi_cnt_reg <= 13'h0000;
      end else begin
        hi_cnt_reg <= hi_cnt_reg + 13'(pwm_s2);
      end
    end
  end

  assign scaled_prod = 15'(ramp_reg) * 15'(duty_reg);

  // Output drivers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_group_level <= 7'h00;
      secondary_group_level <= 7'h00;
      sink_enable <= 8'h00;
      sense_res_sel <= 4'h0;
      current_zone <= 3'd0;
    end else begin
      // ordinary brightness when not zone driven
      main_group_level <= !zone_a ? grpa_brt_reg :
                          config_reg[`ALZ_CFG_PWM_EN] ? scaled_prod[13:7] : ramp_reg;
      secondary_group_level <= !zone_b ? grpb_brt_reg :
                               config_reg[`ALZ_CFG_PWM_EN] ? scaled_prod[13:7] : ramp_reg;
      sink_enable <= led_ctrl_reg;
      sense_res_sel <= res_sel_reg[7:4];
      current_zone <= zone_reg;
    end
  end

  // Checks
  a_zone_range: assert property (@(posedge clk) disable iff (sys_rst) zone_reg <= 3'd4)
    else $error("zone code out of range");
  a_flag_on_move: assert property (@(posedge clk) disable iff (sys_rst)
    zone_reg != $past(zone_reg) |-> flag_reg)
    else $error("zone moved without flag");
  a_move_needs_pair: assert property (@(posedge clk) disable iff (sys_rst)
    zone_reg != $past(zone_reg) |-> $past(avg_done_reg) && $past(trend_reg) != TR_REST)
    else $error("zone moved without two results");
  a_move_to_latest: assert property (@(posedge clk) disable iff (sys_rst)
    zone_reg != $past(zone_reg) |-> zone_reg == last_avg_reg)
    else $error("zone not latest average");
  a_no_up_after_down: assert property (@(posedge clk) disable iff (sys_rst)
    avg_done_reg && trend_reg == TR_DOWN && trend_now == TR_UP |=> zone_reg == $past(zone_reg))
    else $error("zone moved on reversal");
  a_ramp_one_step: assert property (@(posedge clk) disable iff (sys_rst)
    ramp_reg != $past(ramp_reg) |-> $past(ramp_tick) &&
    (ramp_reg == $past(ramp_reg) + 7'd1 || ramp_reg == $past(ramp_reg) - 7'd1))
    else $error("ramp jumped");
  a_sample_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    sample_tick |=> (!sample_tick) [*8])
    else $error("sample enable too dense");
  // Checked on the first edge after release, before any write can land
  a_bound_default: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst |-> bound_reg[0] == 8'h33 && bound_reg[3] == 8'hcc)
    else $error("boundary reset wrong");
  a_target_default: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst |-> target_reg[0] == 7'h19 && target_reg[4] == 7'h7f)
    else $error("target reset wrong");
  a_manual_level: assert property (@(posedge clk) disable iff (sys_rst)
    !zone_a ##1 !$past(sys_rst) |-> main_group_level == $past(grpa_brt_reg))
    else $error("manual level not followed");
  c_zone_move: cover property (@(posedge clk) disable iff (sys_rst) zone_reg != $past(zone_reg));
  c_flag_clear: cover property (@(posedge clk) disable iff (sys_rst) $fell(flag_reg));
  c_pwm_scale: cover property (@(posedge clk) disable iff (sys_rst)
    zone_a && config_reg[`ALZ_CFG_PWM_EN] && duty_reg < 8'h80);
endmodule

// *** verification/alz_light_sensor.sv ***
// Model of the light sensor driving the converter code.
// Assumes the bench picks the level; LSB ripple acts as noise.
`timescale 1ns/1ps
module alz_light_sensor (
  // Clock and requested level
  input wire logic clk,
  input wire logic [7:0] light_level,
  // Code toward the block
  output logic [7:0] ambient_code
);
  logic ripple_reg = 1'b0; // Never static, like a real sensor
  // Level with one-code ripple when the level is even
  always_ff @(posedge clk) begin
    ripple_reg <= ~ripple_reg;
    ambient_code <= light_level | {7'h0, ripple_reg};
  end
endmodule

// *** verification/alz_backlight_zone_tb.sv ***
// Bench: register map, level selection, ramp and PWM scaling.
// Assumes SDA pulled up; the I2C master is bit-banged here.
`timescale 1ns/1ps
module alz_backlight_zone_tb;
  logic clk = 1'b0, sys_rst = 1'b1, scl = 1'b1, sda_m = 1'b1, pwm = 1'b0;
  logic [7:0] lvl = 8'h20, code, sink, rd_v, x, y;
  logic [3:0] res;
  logic [6:0] lv_a, lv_b;
  logic [2:0] zone;
  logic sda_o, sda_oe, ack;
  logic [31:0] seed = 32'd18298;
  logic [5:0] pc = 6'h0;
  logic [7:0] bnd [4] = '{8'h33, 8'h66, 8'h99, 8'hcc};
  logic [7:0] tgt [5] = '{8'h99, 8'hb3, 8'hcc, 8'he6, 8'hff};
  int miscompares = 0, n_compared = 0, i, pwm_hi = 64;
  wire sda_w = sda_m & ~sda_oe; // Open drain with pull-up
  always #25 clk = ~clk;
  // PWM source, duty pwm_hi/64
  always @(posedge clk) begin
    pc <= pc + 6'h1;
    pwm <= (pc < pwm_hi);
  end
  alz_backlight_zone dut_u (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe(sda_oe), .ambient_code(code), .pwm_in(pwm), .sense_res_sel(res),
    .sink_enable(sink), .main_group_level(lv_a), .secondary_group_level(lv_b), .current_zone(zone));
  alz_light_sensor sns_u (.clk(clk), .light_level(lvl), .ambient_code(code));
  // Xorshift, fixed seed
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit; SDA moves only while SCL is low
  task automatic bt(input logic b, output logic r);
    w(4);
    sda_m <= b;
    w(4);
    scl <= 1'b1;
    w(8);
    r = sda_w;
    scl <= 1'b0;
  endtask
  task automatic by(input logic [7:0] d, input logic m, output logic [7:0] r);
    for (int k = 7; k >= 0; k--) bt(d[k], r[k]);
    bt(m, ack);
  endtask
  task automatic st();
    w(4);
    sda_m <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(8);
    sda_m <= 1'b0;
    w(8);
    scl <= 1'b0;
  endtask
  task automatic sp();
    w(4);
    sda_m <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(8);
    sda_m <= 1'b1;
    w(8);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] t;
    st();
    by(8'h6c, 1'b1, t);
    by(a, 1'b1, t);
    by(d, 1'b1, t);
    sp();
  endtask
  // Pointer write, repeated start, one byte, NACK
  task automatic rd(input logic [7:0] a);
    logic [7:0] t;
    st();
    by(8'h6c, 1'b1, t);
    by(a, 1'b1, t);
    st();
    by(8'h6d, 1'b1, t);
    by(8'hff, 1'b1, rd_v);
    sp();
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog over the expected run length
  initial begin
    w(95000);
    miscompares++;
    end_sim();
  end
  initial begin
    w(16);
    sys_rst <= 1'b0;
    lvl <= rnd();
    w(4);
    cmp(sink, 8'h00);
    cmp({5'h0, zone}, 8'h00);
    for (i = 0; i < 4; i++) begin
      rd(8'h60 + i[7:0]);
      cmp(rd_v, bnd[i]);
      x = rnd();
      wr(8'h60 + i[7:0], x);
      rd(8'h60 + i[7:0]);
      cmp(rd_v, x);
    end
    for (i = 0; i < 5; i++) begin
      rd(8'h70 + i[7:0]);
      cmp(rd_v, tgt[i]);
    end
    rd(8'h40);
    cmp(rd_v, 8'hf0);
    rd(8'h30);
    cmp(rd_v, 8'h00); // Unmapped offset reads zero
    for (i = 0; i < 8; i++) begin
      wr(8'h50, {1'b0, i[2:0], 4'h0});
      rd(8'h50);
      cmp(rd_v, {1'b0, i[2:0], 4'h2});
    end
    wr(8'h50, 8'h40);
    rd(8'h50);
    cmp(rd_v, 8'h42);
    wr(8'h51, 8'h40);
    cmp({4'h0, res}, 8'h04);
    x = rnd() & 8'h7f;
    y = rnd() & 8'h7f;
    wr(8'ha0, x);
    wr(8'hb0, y);
    cmp({1'b0, lv_a}, x);
    // sensing on before the LEDs light
    wr(8'h20, 8'hdc);
    w(4);
    cmp({1'b0, lv_a}, 8'h19);
    cmp({1'b0, lv_b}, y);
    wr(8'h10, 8'h3f);
    cmp(sink, 8'h3f);
    wr(8'h70, 8'h1c);
    w(3000);
    cmp({7'h0, lv_a != 7'h1c}, 8'h01);
    w(6000);
    cmp({1'b0, lv_a}, 8'h1c);
    pwm_hi = 0;
    wr(8'h20, 8'hfd);
    w(9000);
    cmp({1'b0, lv_a}, 8'h00);
    cmp({1'b0, lv_b}, 8'h00);
    pwm_hi = 32;
    w(9000);
    cmp({1'b0, lv_a}, 8'h0e);
    cmp({1'b0, lv_b}, 8'h0e);
    end_sim();
  end
endmodule
